// [rtl/rst_nmi_pkg.sv]
// Contract
// [RULE_01] boot vector bus covers bits 31:1
// [RULE_02] reset active low, synchronous release
// [RULE_03] first fetch from boot vector, bit0 zero
// [RULE_04] soc boot vector targets valid memory
// [RULE_05] registers x1..x31 cleared on reset
// [RULE_06] nmi vector bus bits 31:1, soc-driven
// [RULE_07] nmi target ignores interrupt mode
// [RULE_08] nmi pin synchronized, rising edge taken
// [RULE_09] soc holds nmi pin two cycles
// [RULE_10] soc lowers pin two cycles between requests; the soc end holds it low three cycles (pin_min_cycles plus one)
// [RULE_11] unused nmi pin tied low
// [RULE_12] store/nonblocking load bus error raises nmi
// [RULE_13] any nmi fetches from nmi vector
// [RULE_14] cause codes: pin, store, load
// [RULE_15] first error address captured and locked
// [RULE_16] unlock write or reset reopens capture
// [RULE_17] two-stage sync plus edge detect
package rst_nmi_pkg;
   localparam int unsigned vec_width = 31;
   localparam int unsigned gpr_count = 32;
   localparam logic [31:0] cause_nmi_pin = 32'h0000_0000;
   localparam logic [31:0] cause_store_err = 32'hf000_0000;
   localparam logic [31:0] cause_load_err = 32'hf000_0001;
   localparam logic [31:0] err_addr_reset = 32'h0000_0000;
   localparam logic [31:0] zero_word = 32'h0000_0000;
   localparam int unsigned pin_min_cycles = 2;
   typedef logic [vec_width-1:0] vec_type;
   typedef logic [31:0] word_type;
   typedef enum logic [3:0] {
      st_reset = 4'h1,
      st_boot = 4'h2,
      st_run = 4'h4,
      st_nmi = 4'h8
   } core_state_type;
endpackage

// [rtl/rst_nmi_if.sv]
`timescale 1ns/100ps
interface rst_nmi_if;
   import rst_nmi_pkg::*;
   logic reset_n_core;
   vec_type boot_vec;
   vec_type nmi_vec;
   logic nmi_pin;
   modport soc (output reset_n_core, output boot_vec, output nmi_vec, output nmi_pin);
   modport core (input reset_n_core, input boot_vec, input nmi_vec, input nmi_pin);
endinterface

// [rtl/soc_rst_nmi_ctrl.sv]
`timescale 1ns/100ps
module soc_rst_nmi_ctrl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire rst_nmi_pkg::vec_type boot_addr,
   input wire rst_nmi_pkg::vec_type nmi_addr,
   input wire logic nmi_request,
   input wire logic nmi_enable,
   output logic nmi_busy,
   rst_nmi_if.soc link
);
   import rst_nmi_pkg::*;
   // ****************************************
   // reset release synchronous to the core clock
   // ****************************************
   logic rst_meta_ff;
   logic rst_sync_ff;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1; // RULE_02
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign link.reset_n_core = rst_sync_ff;
   // ****************************************
   // vector registers
   // ****************************************
   vec_type boot_ff, nxt_boot;
   vec_type nmiv_ff, nxt_nmiv;
   always_comb begin
      nxt_boot = boot_addr; // RULE_01 RULE_04
      nxt_nmiv = nmi_addr; // RULE_06
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_ff <= '0;
         nmiv_ff <= '0;
      end else begin
         boot_ff <= nxt_boot;
         nmiv_ff <= nxt_nmiv;
      end
   end
   assign link.boot_vec = boot_ff;
   assign link.nmi_vec = nmiv_ff;
   // ****************************************
   // nmi pin pulse shaping
   // ****************************************
   // high for pin_min_cycles, then low for pin_min_cycles plus one before another
   logic pin_ff, nxt_pin;
   logic [1:0] cnt_ff, nxt_cnt;
   logic busy_ff, nxt_busy;
   always_comb begin
      nxt_pin = pin_ff;
      nxt_cnt = cnt_ff;
      nxt_busy = busy_ff;
      // a pulse once begun runs its full shape even if enable drops, so no
      // short pulse reaches the pin
      if (busy_ff) begin
         if (cnt_ff != 2'h0) begin
            nxt_cnt = cnt_ff - 2'h1;
         end else if (pin_ff) begin
            nxt_pin = 1'b0;
            nxt_cnt = 2'(pin_min_cycles - 1); // RULE_10
         end else begin
            nxt_busy = 1'b0;
         end
      end else if (nmi_request && nmi_enable) begin // RULE_11
         nxt_pin = 1'b1;
         nxt_cnt = 2'(pin_min_cycles - 1); // RULE_09
         nxt_busy = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_ff <= 1'b0;
         cnt_ff <= 2'h0;
         busy_ff <= 1'b0;
      end else begin
         pin_ff <= nxt_pin;
         cnt_ff <= nxt_cnt;
         busy_ff <= nxt_busy;
      end
   end
   assign link.nmi_pin = pin_ff;
   assign nmi_busy = busy_ff;
endmodule // soc_rst_nmi_ctrl

// [rtl/core_rst_nmi_unit.sv]
`timescale 1ns/100ps
module core_rst_nmi_unit #(
   parameter int unsigned gpr_num = rst_nmi_pkg::gpr_count
) (
   input wire logic ref_clk,
   rst_nmi_if.core link,
   input wire logic vectored_mode,
   input wire logic store_err,
   input wire logic load_err,
   input wire rst_nmi_pkg::word_type err_addr,
   input wire logic unlock_wr,
   input wire logic [4:0] gpr_waddr,
   input wire rst_nmi_pkg::word_type gpr_wdata,
   input wire logic gpr_we,
   input wire logic [4:0] gpr_raddr,
   output rst_nmi_pkg::word_type gpr_rdata,
   output rst_nmi_pkg::word_type fetch_addr,
   output logic fetch_valid,
   output rst_nmi_pkg::word_type trap_cause,
   output rst_nmi_pkg::word_type err_capture,
   output logic err_locked,
   output rst_nmi_pkg::word_type unlock_rdata
);
   import rst_nmi_pkg::*;
   // ****************************************
   // core reset and helpers
   // ****************************************
   // the soc end already releases this reset in step with ref_clk
   logic reset_n;
   assign reset_n = link.reset_n_core; // RULE_02
   // vectors carry address bits 31:1; a fetch address always has bit 0 clear
   function automatic word_type vec_to_addr(input vec_type vec);
      return {vec, 1'b0}; // RULE_03 RULE_13
   endfunction
   // pin first, then store, then load, when causes coincide
   function automatic word_type nmi_cause(input logic from_pin, input logic from_store);
      word_type code;
      if (from_pin) begin
         code = cause_nmi_pin; // RULE_14
      end else if (from_store) begin
         code = cause_store_err; // RULE_14
      end else begin
         code = cause_load_err; // RULE_14
      end
      return code;
   endfunction
   // ****************************************
   // nmi pin synchronizer and edge detect
   // ****************************************
   logic pin_meta_ff, nxt_pin_meta;
   logic pin_sync_ff, nxt_pin_sync;
   logic pin_last_ff, nxt_pin_last;
   logic pin_rise;
   // the pin is treated as asynchronous even though the soc end registers it,
   // so a pin raised from another clock domain needs no change here
   always_comb begin
      nxt_pin_meta = link.nmi_pin; // RULE_08 RULE_17
      nxt_pin_sync = pin_meta_ff;
      nxt_pin_last = pin_sync_ff;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
         pin_last_ff <= 1'b0;
      end else begin
         pin_meta_ff <= nxt_pin_meta;
         pin_sync_ff <= nxt_pin_sync;
         pin_last_ff <= nxt_pin_last;
      end
   end
   // last starts low like the idle pin, so no false edge follows reset
   assign pin_rise = pin_sync_ff & ~pin_last_ff; // RULE_08 RULE_17
   // ****************************************
   // bus error capture and lock
   // ****************************************
   logic bus_err;
   logic err_nmi;
   word_type cap_ff, nxt_cap;
   logic lock_ff, nxt_lock;
   assign bus_err = store_err | load_err;
   // while locked an error leaves neither an address nor an nmi behind
   assign err_nmi = bus_err & ~lock_ff; // RULE_12 RULE_15
   always_comb begin
      nxt_cap = cap_ff;
      nxt_lock = lock_ff;
      // a fresh error beats an unlock in the same cycle only if already unlocked; while locked, an error that comes with the unlock is lost
      if (unlock_wr) begin
         nxt_lock = 1'b0; // RULE_16
      end
      if (err_nmi) begin
         nxt_cap = err_addr; // RULE_15
         nxt_lock = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_ff <= err_addr_reset;
         lock_ff <= 1'b0; // RULE_16
      end else begin
         cap_ff <= nxt_cap;
         lock_ff <= nxt_lock;
      end
   end
   // ****************************************
   // fetch redirection and cause
   // ****************************************
   core_state_type state_ff, nxt_state;
   word_type fetch_ff, nxt_fetch;
   logic fvalid_ff, nxt_fvalid;
   word_type cause_ff, nxt_cause;
   always_comb begin
      nxt_state = state_ff;
      nxt_fetch = fetch_ff;
      nxt_fvalid = 1'b0;
      nxt_cause = cause_ff;
      case (state_ff)
         st_reset: begin
            nxt_fetch = vec_to_addr(link.boot_vec); // RULE_01 RULE_03
            nxt_fvalid = 1'b1;
            nxt_state = st_boot;
         end
         st_boot, st_run, st_nmi: begin
            nxt_state = st_run;
            // vectored_mode deliberately unused here: nmi target fixed
            // an nmi in the cycle right after boot is taken at once
            if (pin_rise || err_nmi) begin
               nxt_fetch = vec_to_addr(link.nmi_vec); // RULE_06 RULE_07 RULE_13
               nxt_fvalid = 1'b1;
               nxt_state = st_nmi;
               nxt_cause = nmi_cause(pin_rise, store_err); // RULE_14
            end
         end
         default: begin
            nxt_state = st_reset;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= st_reset;
         fetch_ff <= zero_word;
         fvalid_ff <= 1'b0;
         cause_ff <= zero_word;
      end else begin
         state_ff <= nxt_state;
         fetch_ff <= nxt_fetch;
         fvalid_ff <= nxt_fvalid;
         cause_ff <= nxt_cause;
      end
   end
   // ****************************************
   // integer register file
   // ****************************************
   word_type gpr_ff [gpr_num];
   word_type nxt_gpr [gpr_num];
   word_type rdata_ff, nxt_rdata;
   // a write and a read of one register in one cycle returns the old value
   always_comb begin
      for (int i = 0; i < gpr_num; i++) begin
         nxt_gpr[i] = gpr_ff[i];
      end
      if (gpr_we && gpr_waddr != 5'h00) begin
         nxt_gpr[gpr_waddr] = gpr_wdata;
      end
      nxt_rdata = (gpr_raddr == 5'h00) ? zero_word : gpr_ff[gpr_raddr];
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < gpr_num; i++) begin
            gpr_ff[i] <= zero_word; // RULE_05
         end
         rdata_ff <= zero_word;
      end else begin
         for (int i = 0; i < gpr_num; i++) begin
            gpr_ff[i] <= nxt_gpr[i];
         end
         rdata_ff <= nxt_rdata;
      end
   end
   // ****************************************
   // unlock register read side
   // ****************************************
   // reads as zero from a flop, so every output leaves a register
   word_type unlock_rd_ff, nxt_unlock_rd;
   always_comb begin
      nxt_unlock_rd = zero_word; // RULE_16
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         unlock_rd_ff <= zero_word;
      end else begin
         unlock_rd_ff <= nxt_unlock_rd;
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   // the mode select is taken only to show that the nmi target ignores it
   logic unused_mode;
   assign unused_mode = vectored_mode; // RULE_07
   assign gpr_rdata = rdata_ff;
   assign fetch_addr = fetch_ff;
   assign fetch_valid = fvalid_ff;
   assign trap_cause = cause_ff;
   assign err_capture = cap_ff;
   assign err_locked = lock_ff;
   assign unlock_rdata = unlock_rd_ff; // RULE_16
endmodule // core_rst_nmi_unit

// [tb/rst_nmi_asserts.sv]
`timescale 1ns/100ps
module rst_nmi_asserts (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic reset_n_core,
   input wire rst_nmi_pkg::vec_type boot_vec,
   input wire rst_nmi_pkg::vec_type nmi_vec,
   input wire logic nmi_pin
);
   import rst_nmi_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ************
   // core reset release and pin pulse shape
   // ************
   sequence high_run;
      nmi_pin [*2];
   endsequence
   sequence low_run;
      !nmi_pin [*2];
   endsequence
   sequence core_release;
      !reset_n_core ##1 !reset_n_core ##1 reset_n_core;
   endsequence
   a_core_rst_rel: assert property ($rose(reset_n) |-> core_release)
      else $error("core reset not released two edges after reset");
   a_core_rst_hold: assert property (reset_n && !$past(reset_n) |-> !reset_n_core && boot_vec == '0 && !nmi_pin)
      else $error("core reset or link outputs not held on first edge");
   a_core_rst_sync: assert property ($rose(reset_n_core) |-> $past(reset_n))
      else $error("core reset released without clocked delay");
   a_pin_high_two: assert property ($rose(nmi_pin) |-> high_run)
      else $error("pin pulse shorter than two cycles");
   a_pin_high_end: assert property ($rose(nmi_pin) ##1 nmi_pin |=> !nmi_pin)
      else $error("pin pulse longer than two cycles");
   a_pin_low_two: assert property ($fell(nmi_pin) |-> low_run)
      else $error("pin gap shorter than two cycles");
endmodule // rst_nmi_asserts

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
   import rst_nmi_pkg::*;
   logic ref_clk, reset_n, nmi_request, nmi_enable, nmi_busy, vectored_mode, store_err, load_err;
   logic unlock_wr, gpr_we, fetch_valid, err_locked;
   vec_type boot_addr, nmi_addr;
   word_type err_addr, gpr_wdata, gpr_rdata, fetch_addr, trap_cause, err_capture, unlock_rdata;
   logic [4:0] gpr_waddr, gpr_raddr;
   int miscompares = 0;
   int tests_run = 0;
   int tn = 0;
   int c;
   rst_nmi_if link ();
   soc_rst_nmi_ctrl u_soc_rst_nmi_ctrl (.*);
   core_rst_nmi_unit u_core_rst_nmi_unit (.*);
   rst_nmi_asserts u_rst_nmi_asserts (.ref_clk(ref_clk), .reset_n(reset_n), .reset_n_core(link.reset_n_core),
      .boot_vec(link.boot_vec), .nmi_vec(link.nmi_vec), .nmi_pin(link.nmi_pin));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ************
   // helpers
   // ************
   task tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task chk(input word_type seen, input word_type exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task end_test;
      tn++;
      $display("test %0d done", tn);
   endtask
   // fetch_valid stands one cycle, so it is polled every falling edge
   task expect_fetch(input word_type addr, input word_type cause);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 20 && !seen; i++) begin
         if (fetch_valid === 1'b1) seen = 1'b1;
         else tick(1);
      end
      if (!seen) begin
         miscompares++;
         $display("BAD %0t no fetch within bound", $time);
         close_out;
      end else begin
         chk(fetch_addr, addr);
         chk(trap_cause, cause);
         tick(1);
      end
   endtask
   task count_nmi(input int n);
      c = 0;
      repeat (n) begin
         if (fetch_valid === 1'b1) c++;
         tick(1);
      end
   endtask
   task do_reset;
      reset_n = 1'b0;
      tick(10);
      reset_n = 1'b1;
   endtask
   initial begin
      #200000;
      miscompares++;
      $display("BAD %0t run limit reached", $time);
      close_out;
   end
   initial begin
      {reset_n, nmi_request, vectored_mode, store_err, load_err, unlock_wr, gpr_we} = '0;
      {gpr_waddr, gpr_raddr, gpr_wdata, err_addr} = '0;
      nmi_enable = 1'b1;
      boot_addr = 31'h2000_0040;
      nmi_addr = 31'h3000_0100;
      do_reset;
      expect_fetch({boot_addr, 1'b0}, zero_word);
      chk(err_capture, err_addr_reset);
      gpr_we = 1'b1;
      gpr_waddr = 5'h05;
      gpr_wdata = 32'ha5a5_0001;
      tick(1);
      gpr_we = 1'b0;
      gpr_raddr = 5'h05;
      tick(1);
      chk(gpr_rdata, 32'ha5a5_0001);
      end_test;
      err_addr = 32'h0000_8010;
      store_err = 1'b1;
      tick(1);
      store_err = 1'b0;
      expect_fetch({nmi_addr, 1'b0}, cause_store_err);
      chk(err_capture, 32'h0000_8010);
      chk(err_locked, 1'b1);
      err_addr = 32'h0000_9020;
      load_err = 1'b1;
      tick(1);
      load_err = 1'b0;
      count_nmi(8);
      chk(c, 0);
      chk(err_capture, 32'h0000_8010);
      end_test;
      // pin still taken while locked, and vectored mode must not move the target
      vectored_mode = 1'b1;
      nmi_request = 1'b1;
      tick(1);
      nmi_request = 1'b0;
      expect_fetch({nmi_addr, 1'b0}, cause_nmi_pin);
      count_nmi(10);
      chk(c, 0);
      unlock_wr = 1'b1;
      tick(1);
      unlock_wr = 1'b0;
      chk(err_locked, 1'b0);
      chk(unlock_rdata, zero_word);
      load_err = 1'b1;
      tick(1);
      load_err = 1'b0;
      expect_fetch({nmi_addr, 1'b0}, cause_load_err);
      chk(err_capture, 32'h0000_9020);
      end_test;
      nmi_enable = 1'b0;
      nmi_request = 1'b1;
      tick(1);
      nmi_request = 1'b0;
      count_nmi(10);
      chk(c, 0);
      chk(nmi_busy, 1'b0);
      nmi_enable = 1'b1;
      for (int k = 0; k < 2; k++) begin
         nmi_request = 1'b1;
         tick(1);
         nmi_request = 1'b0;
         chk(nmi_busy, 1'b1);
         count_nmi(12);
         chk(c, 1);
         chk(nmi_busy, 1'b0);
      end
      end_test;
      do_reset;
      expect_fetch({boot_addr, 1'b0}, zero_word);
      chk(err_locked, 1'b0);
      chk(err_capture, err_addr_reset);
      for (int r = 1; r < 32; r++) begin
         gpr_raddr = r[4:0];
         tick(1);
         chk(gpr_rdata, zero_word);
      end
      end_test;
      close_out;
   end
endmodule // tb
